// *** logic/boost_ctrl_config_status_regs.sv ***
// Configuration and status register bank of the dual-phase boost controller.
// Assumes an internal serial-bus engine presents pointer loads and data bytes as
// single-cycle strobes on clk, and that analog monitors arrive already synchronised.
`timescale 1ns/10ps
`default_nettype none
module boost_ctrl_config_status_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic booted,
  input wire logic busy,
  input wire logic ptr_load,
  input wire logic [7:0] ptr_value,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_data,
  input wire logic rd_strobe,
  input wire boost_regs_pkg::monitor_in_t mon,
  output logic [7:0] rd_data_q,
  output logic ack_q,
  output logic nack_q,
  output logic [7:0] ptr_q,
  output logic [7:0] fault_flags_q,
  output logic fault_pin_out_q,
  output logic fault_pin_oe_q,
  output boost_regs_pkg::power_ctrl_t ctrl_q
);

  // ****************************************
  // Lookup functions
  // ****************************************
  function automatic logic [6:0] warn_margin(input logic [1:0] code);
    case (code)
      2'h0: warn_margin = 7'h14;
      2'h1: warn_margin = 7'h23;
      2'h2: warn_margin = 7'h32;
      default: warn_margin = 7'h46;
    endcase
  endfunction

  function automatic logic [7:0] dead_time(input logic [2:0] code);
    case (code)
      3'h0: dead_time = 8'h0E;
      3'h1: dead_time = 8'h1E;
      3'h2: dead_time = 8'h32;
      3'h3: dead_time = 8'h4B;
      3'h4: dead_time = 8'h64;
      3'h5: dead_time = 8'h7D;
      3'h6: dead_time = 8'h96;
      default: dead_time = 8'hC8;
    endcase
  endfunction

  function automatic logic uses_sync_input(input logic [2:0] role);
    uses_sync_input = !(role == boost_regs_pkg::ROLE_SINGLE ||
                        role == boost_regs_pkg::ROLE_PRIMARY_240 ||
                        role == boost_regs_pkg::ROLE_PRIMARY_180);
  endfunction

  function automatic logic drives_sync_output(input logic [2:0] role);
    drives_sync_output = (role >= boost_regs_pkg::ROLE_PRIMARY_240) &&
                         (role <= boost_regs_pkg::ROLE_PRIMARY_EXT_180);
  endfunction

  // ****************************************
  // State
  // ****************************************
  boost_regs_pkg::regs_state_t s_q;
  boost_regs_pkg::regs_state_t s_d;

  logic accepted;
  logic [7:0] fault_set;
  logic clear_access;
  logic warn_now;
  logic [1:0] mode_field;
  logic [2:0] role_field;
  logic [7:0] flags;

  // Both read and write strobes count as an access; the data byte is irrelevant.
  assign accepted = booted && !busy && (rd_strobe || wr_strobe); // RQ20
  assign clear_access = accepted && s_q.ptr == boost_regs_pkg::OFS_FAULT_CLEAR_STROBE; // RQ18
  assign mode_field = s_q.protection_mode_setup[boost_regs_pkg::BIT_MODE_HI:
                                                boost_regs_pkg::BIT_MODE_LO];
  assign role_field = s_q.timing_role_setup[boost_regs_pkg::BIT_ROLE_HI:
                                            boost_regs_pkg::BIT_ROLE_LO];
  assign warn_now = mon.temp_margin_c <= {1'b0, s_q.ctrl.warn_margin_c}; // RQ16

  always_comb begin
    fault_set = '0;
    fault_set[boost_regs_pkg::FLT_COMM_LOGIC_MEMORY] = mon.comm_logic_memory_error; // RQ15
    fault_set[boost_regs_pkg::FLT_HIGH_SIDE_SUPPLY] = mon.high_side_supply_uv;
    fault_set[boost_regs_pkg::FLT_PEAK_LIMIT] = mon.peak_over20;
    fault_set[boost_regs_pkg::FLT_AVG_INPUT_LIMIT] = mon.avg_input_limit;
    fault_set[boost_regs_pkg::FLT_OUTPUT_OV] = mon.ov_detect || mon.ovmax_detect;
    fault_set[boost_regs_pkg::FLT_OUTPUT_UV] = mon.uv_detect;
    fault_set[boost_regs_pkg::FLT_THERMAL_SHUTDOWN] = mon.thermal_shutdown;
    fault_set[boost_regs_pkg::FLT_THERMAL_WARNING] = warn_now; // RQ16
  end

  fault_latch_bank #(
    .WIDTH(8)
  ) u_fault_latch (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .set(fault_set),
    .clear(clear_access),
    .flags_q(flags)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.nack = 1'b0;
    // Refusal is an immediate nack rather than a wait, since the bus is never stretched.
    if (rd_strobe || wr_strobe) begin
      s_d.ack = accepted; // RQ20
      s_d.nack = !accepted;
    end
    if (ptr_load) begin
      s_d.ptr = ptr_value;
    end else if (accepted) begin
      s_d.ptr = s_q.ptr + 8'h01; // RQ19
    end
    if (accepted && wr_strobe) begin
      case (s_q.ptr)
        boost_regs_pkg::OFS_PROTECTION_MODE_SETUP: begin
          s_d.protection_mode_setup = wr_data;
        end
        boost_regs_pkg::OFS_TIMING_ROLE_SETUP: begin
          s_d.timing_role_setup = wr_data;
        end
        default: begin
          s_d.ptr = s_d.ptr; // RQ21
        end
      endcase
    end
    if (accepted && rd_strobe) begin
      case (s_q.ptr)
        boost_regs_pkg::OFS_PROTECTION_MODE_SETUP: s_d.rd_data = s_q.protection_mode_setup;
        boost_regs_pkg::OFS_TIMING_ROLE_SETUP: s_d.rd_data = s_q.timing_role_setup;
        boost_regs_pkg::OFS_RUN_PHASE_REPORT: begin
          s_d.rd_data = {4'h0, mon.run_phase} & boost_regs_pkg::STATE_READ_MASK; // RQ13 RQ14
        end
        boost_regs_pkg::OFS_FAULT_FLAGS: s_d.rd_data = flags;
        default: s_d.rd_data = 8'h00;
      endcase
    end

    // Protection latches hold until reset; a later clear of the flags does not restart.
    if (mon.ovmax_detect &&
        s_q.protection_mode_setup[boost_regs_pkg::BIT_OV_SHUTDOWN_LATCH]) begin
      s_d.ov_latched = 1'b1; // RQ1
    end
    if (mon.peak_over20 &&
        s_q.protection_mode_setup[boost_regs_pkg::BIT_PEAK_LIMIT_LATCH]) begin
      s_d.peak_latched = 1'b1; // RQ4
    end
    s_d.ctrl.shutdown = s_d.ov_latched || s_d.peak_latched;
    s_d.ctrl.ov_hysteresis_en =
      !s_q.protection_mode_setup[boost_regs_pkg::BIT_OV_SHUTDOWN_LATCH]; // RQ1

    if (s_q.protection_mode_setup[boost_regs_pkg::BIT_FAULT_PIN_ON_OV]) begin
      s_d.fault_pin_oe = mon.ov_detect || mon.ovmax_detect || mon.uv_detect; // RQ3
    end else begin
      s_d.fault_pin_oe = mon.uv_detect; // RQ3
    end

    case (mode_field)
      boost_regs_pkg::MODE_FOLLOW_PIN: begin
        s_d.ctrl.forced_pulse_width = mon.mode_pin_forced_pulse_width; // RQ2
      end
      boost_regs_pkg::MODE_DIODE_EMULATION: begin
        s_d.ctrl.forced_pulse_width = 1'b0;
      end
      default: begin
        s_d.ctrl.forced_pulse_width = 1'b1;
      end
    endcase
    s_d.ctrl.diode_emulation = !s_d.ctrl.forced_pulse_width;

    s_d.ctrl.dither_en = s_q.protection_mode_setup[boost_regs_pkg::BIT_DITHER_EN] &&
                         !uses_sync_input(role_field); // RQ5 RQ11
    s_d.ctrl.phase2_en = s_q.protection_mode_setup[boost_regs_pkg::BIT_SECOND_PHASE_FORCE] ||
                         mon.en2_pin; // RQ6
    s_d.ctrl.lockout_ok = s_q.protection_mode_setup[boost_regs_pkg::BIT_LOCKOUT_OVERRIDE] ||
                          mon.lockout_pin_ok; // RQ7
    s_d.ctrl.warn_margin_c = warn_margin(
      s_q.timing_role_setup[boost_regs_pkg::BIT_WARN_HI:boost_regs_pkg::BIT_WARN_LO]); // RQ8
    s_d.ctrl.dead_time_ns = dead_time(
      s_q.timing_role_setup[boost_regs_pkg::BIT_DEAD_HI:boost_regs_pkg::BIT_DEAD_LO]); // RQ9

    s_d.ctrl.sync_input_en = uses_sync_input(role_field); // RQ10
    s_d.ctrl.sync_output_en = drives_sync_output(role_field);
    case (role_field)
      boost_regs_pkg::ROLE_PRIMARY_240, boost_regs_pkg::ROLE_PRIMARY_EXT_240: begin
        s_d.ctrl.phase2_deg = boost_regs_pkg::PHASE_DEG_240; // RQ12
        s_d.ctrl.sync_shift_deg = boost_regs_pkg::SHIFT_DEG_120;
      end
      boost_regs_pkg::ROLE_PRIMARY_180, boost_regs_pkg::ROLE_PRIMARY_EXT_180: begin
        s_d.ctrl.phase2_deg = boost_regs_pkg::PHASE_DEG_180; // RQ12
        s_d.ctrl.sync_shift_deg = boost_regs_pkg::SHIFT_DEG_90;
      end
      default: begin
        s_d.ctrl.phase2_deg = boost_regs_pkg::PHASE_DEG_180;
        s_d.ctrl.sync_shift_deg = boost_regs_pkg::SHIFT_DEG_NONE;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.protection_mode_setup <= boost_regs_pkg::RST_PROTECTION_MODE_SETUP;
      s_q.timing_role_setup <= boost_regs_pkg::RST_TIMING_ROLE_SETUP;
      s_q.ptr <= boost_regs_pkg::RST_POINTER;
      s_q.ctrl.phase2_deg <= boost_regs_pkg::PHASE_DEG_180;
      s_q.ctrl.sync_input_en <= 1'b1;
      s_q.ctrl.dead_time_ns <= 8'h64;
      s_q.ctrl.warn_margin_c <= 7'h32;
      s_q.ctrl.diode_emulation <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rd_data_q = s_q.rd_data;
  assign ack_q = s_q.ack;
  assign nack_q = s_q.nack;
  assign ptr_q = s_q.ptr;
  assign fault_flags_q = flags;
  assign fault_pin_out_q = 1'b0;
  assign fault_pin_oe_q = s_q.fault_pin_oe;
  assign ctrl_q = s_q.ctrl;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ptr_advance_a: assert property (ce && accepted && !ptr_load |=> // RQ19
                                  ptr_q == $past(ptr_q) + 8'h01)
    else $error("Pointer did not advance after an accepted byte.");
  refuse_nack_a: assert property (ce && (rd_strobe || wr_strobe) && !booted |=> // RQ20
                                  nack_q && !ack_q)
    else $error("Byte acknowledged before boot.");
  ro_write_a: assert property (ce && accepted && wr_strobe && // RQ21
                               ptr_q >= boost_regs_pkg::OFS_RUN_PHASE_REPORT |=>
                               $stable(s_q.protection_mode_setup) && $stable(s_q.timing_role_setup))
    else $error("Write to a read-only offset changed a setup register.");
  // An event in the clearing cycle wins over the clear, so only a quiet cycle must empty the byte.
  clear_flags_a: assert property (ce && clear_access && fault_set == 8'h00 |=> // RQ18
                                  fault_flags_q == 8'h00)
    else $error("Fault byte not cleared by an access to the clear offset.");
  sticky_flag_a: assert property (ce && mon.thermal_shutdown && !clear_access |=> // RQ17
                                  fault_flags_q[boost_regs_pkg::FLT_THERMAL_SHUTDOWN])
    else $error("Thermal shutdown flag not latched.");
  state_read_a: assert property (ce && accepted && rd_strobe && // RQ13 RQ14
                                 ptr_q == boost_regs_pkg::OFS_RUN_PHASE_REPORT |=>
                                 rd_data_q[7:4] == 4'h0 && rd_data_q[3:0] == $past(mon.run_phase))
    else $error("State register readback wrong.");
  ov_latch_a: assert property (ce && mon.ovmax_detect && // RQ1
                               s_q.protection_mode_setup[boost_regs_pkg::BIT_OV_SHUTDOWN_LATCH]
                               |=> ##1 ctrl_q.shutdown)
    else $error("Overvoltage latch did not shut down.");
  sync_dither_a: assert property (ctrl_q.sync_input_en |-> !ctrl_q.dither_en) // RQ11
    else $error("Dithering active with external sync input.");
  fault_pin_a: assert property (ce && mon.uv_detect |=> fault_pin_oe_q) // RQ3
    else $error("Fault pin not driven on undervoltage.");

  write_cfg_c: cover property (ce && accepted && wr_strobe &&
                               ptr_q == boost_regs_pkg::OFS_TIMING_ROLE_SETUP);
  seq_read_c: cover property (ce && accepted && rd_strobe ##1 ce && accepted && rd_strobe);
  clear_c: cover property (ce && clear_access && fault_flags_q != 8'h00);
  shutdown_c: cover property (ctrl_q.shutdown);

endmodule
`default_nettype wire

// *** pkg/boost_regs_pkg.sv ***
// Constants, field layouts and carrier types for the configuration and status register bank.
// Assumes the byte-wide register port is driven by an internal serial-bus engine on clk.
// Overview of operation
// RQ1: At top overvoltage level, latch bit 0 gives 1V hysteresis, 1 latches shutdown.
// RQ2: Mode field bits 6-5: 0 mode pin, 1 diode emulation, 2 or 3 forced PWM.
// RQ3: Fault-on-overvoltage set: fault pin low on either overvoltage or undervoltage; else undervoltage.
// RQ4: Peak-limit latch enabled: shut down when peak limit exceeded by 20 percent.
// RQ5: Bit 2 enables clock dithering; reset value 0.
// RQ6: Bit 1 set forces second phase on; clear follows the enable pin.
// RQ7: Bit 0 set overrides undervoltage lockout as above threshold; clear follows pin.
// RQ8: Warning margin bits 7-6 select 20, 35, 50 or 70 degrees; reset code 2.
// RQ9: Dead-time field codes 0-7 give 14 to 200 ns; reset code 4.
// RQ10: Role field selects single, external clock, primary or secondary; reset code 1.
// RQ11: Roles using sync input (1,4,5,6,7) disable dithering; 0,2,3 follow enable bit.
// RQ12: Roles 2 and 4 use 240 and 120 degrees; 3 and 5 use 180 and 90.
// RQ13: State register bits 3-0 report the operating state code 0 to 9.
// RQ14: State register bits 7-4 ignore writes and read zero.
// RQ15: Fault byte bits 7 to 1 flag the seven fault sources; 1 means fault.
// RQ16: Fault byte bit 0 reads 1 when die nears thermal shutdown.
// RQ17: Fault flags stay latched after the condition until cleared.
// RQ18: Any access to offset 6 clears all fault flags, whatever the data.
// RQ19: Register pointer advances by one after each acknowledged data byte.
// RQ20: No clock stretching; no acknowledge while busy or not booted.
// RQ21: Writes to state and fault registers are ignored.
package boost_regs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_PROTECTION_MODE_SETUP = 8'h02;
  localparam logic [7:0] OFS_TIMING_ROLE_SETUP = 8'h03;
  localparam logic [7:0] OFS_RUN_PHASE_REPORT = 8'h04;
  localparam logic [7:0] OFS_FAULT_FLAGS = 8'h05;
  localparam logic [7:0] OFS_FAULT_CLEAR_STROBE = 8'h06;
  localparam logic [7:0] RST_PROTECTION_MODE_SETUP = 8'h80;
  localparam logic [7:0] RST_TIMING_ROLE_SETUP = 8'hA1;
  localparam logic [7:0] RST_POINTER = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_OV_SHUTDOWN_LATCH = 7;
  localparam int BIT_MODE_HI = 6;
  localparam int BIT_MODE_LO = 5;
  localparam int BIT_FAULT_PIN_ON_OV = 4;
  localparam int BIT_PEAK_LIMIT_LATCH = 3;
  localparam int BIT_DITHER_EN = 2;
  localparam int BIT_SECOND_PHASE_FORCE = 1;
  localparam int BIT_LOCKOUT_OVERRIDE = 0;
  localparam int BIT_WARN_HI = 7;
  localparam int BIT_WARN_LO = 6;
  localparam int BIT_DEAD_HI = 5;
  localparam int BIT_DEAD_LO = 3;
  localparam int BIT_ROLE_HI = 2;
  localparam int BIT_ROLE_LO = 0;
  localparam logic [7:0] STATE_READ_MASK = 8'h0F;

  // Fault byte bit positions.
  localparam int FLT_COMM_LOGIC_MEMORY = 7;
  localparam int FLT_HIGH_SIDE_SUPPLY = 6;
  localparam int FLT_PEAK_LIMIT = 5;
  localparam int FLT_AVG_INPUT_LIMIT = 4;
  localparam int FLT_OUTPUT_OV = 3;
  localparam int FLT_OUTPUT_UV = 2;
  localparam int FLT_THERMAL_SHUTDOWN = 1;
  localparam int FLT_THERMAL_WARNING = 0;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [1:0] MODE_FOLLOW_PIN = 2'h0;
  localparam logic [1:0] MODE_DIODE_EMULATION = 2'h1;
  localparam logic [2:0] ROLE_SINGLE = 3'h0;
  localparam logic [2:0] ROLE_PRIMARY_240 = 3'h2;
  localparam logic [2:0] ROLE_PRIMARY_180 = 3'h3;
  localparam logic [2:0] ROLE_PRIMARY_EXT_240 = 3'h4;
  localparam logic [2:0] ROLE_PRIMARY_EXT_180 = 3'h5;
  localparam logic [8:0] PHASE_DEG_180 = 9'h0B4;
  localparam logic [8:0] PHASE_DEG_240 = 9'h0F0;
  localparam logic [6:0] SHIFT_DEG_NONE = 7'h00;
  localparam logic [6:0] SHIFT_DEG_90 = 7'h5A;
  localparam logic [6:0] SHIFT_DEG_120 = 7'h78;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic ov_detect;
    logic ovmax_detect;
    logic uv_detect;
    logic peak_over20;
    logic avg_input_limit;
    logic high_side_supply_uv;
    logic comm_logic_memory_error;
    logic thermal_shutdown;
    logic mode_pin_forced_pulse_width;
    logic en2_pin;
    logic lockout_pin_ok;
    logic [3:0] run_phase;
    logic [7:0] temp_margin_c;
  } monitor_in_t;

  typedef struct packed {
    logic shutdown;
    logic ov_hysteresis_en;
    logic diode_emulation;
    logic forced_pulse_width;
    logic dither_en;
    logic phase2_en;
    logic lockout_ok;
    logic sync_input_en;
    logic sync_output_en;
    logic [8:0] phase2_deg;
    logic [6:0] sync_shift_deg;
    logic [7:0] dead_time_ns;
    logic [6:0] warn_margin_c;
  } power_ctrl_t;

  typedef struct packed {
    logic [7:0] protection_mode_setup;
    logic [7:0] timing_role_setup;
    logic [7:0] ptr;
    logic [7:0] rd_data;
    logic ack;
    logic nack;
    logic ov_latched;
    logic peak_latched;
    logic fault_pin_oe;
    power_ctrl_t ctrl;
  } regs_state_t;

endpackage

// *** logic/fault_latch_bank.sv ***
// Sticky fault flag bank for the fault byte.
// Assumes set inputs and the clear strobe are synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module fault_latch_bank #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] set,
  input wire logic clear,
  output logic [WIDTH-1:0] flags_q
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } latch_state_t;

  latch_state_t s_q;
  latch_state_t s_d;

  // A flag raised in the clearing cycle survives, so no event is lost.
  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d.flags = '0; // RQ18
    end
    s_d.flags = s_d.flags | set; // RQ17
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign flags_q = s_q.flags;

endmodule
`default_nettype wire

// *** bench/host_port_model.sv ***
// Model of the serial-bus engine that feeds the register port of the bank.
// Assumes the bench calls xfer from one process, one transfer at a time.
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
  input wire logic clk,
  input wire logic [7:0] rd_data_q,
  input wire logic ack_q,
  output logic ptr_load,
  output logic [7:0] ptr_value,
  output logic wr_strobe,
  output logic [7:0] wr_data,
  output logic rd_strobe
);
  initial begin
    ptr_load = 1'b0;
    ptr_value = 8'h00;
    wr_strobe = 1'b0;
    wr_data = 8'h00;
    rd_strobe = 1'b0;
  end
  // ****
  // Transfers: kind 0 loads the pointer, 1 writes a byte, 2 reads a byte.
  // ****
  // Each transfer ends by inverting both ptr_value and wr_data, so the line it used idles at the inverse of its byte and a stale value never passes.
  task automatic xfer(input int kind, input logic [7:0] d, output logic [7:0] q,
      output logic a);
    @(posedge clk);
    if (kind == 0) begin
      ptr_load <= 1'b1;
      ptr_value <= d;
    end else if (kind == 1) begin
      wr_strobe <= 1'b1;
      wr_data <= d;
    end else begin
      rd_strobe <= 1'b1;
    end
    @(posedge clk);
    ptr_load <= 1'b0;
    wr_strobe <= 1'b0;
    rd_strobe <= 1'b0;
    ptr_value <= ~ptr_value;
    wr_data <= ~wr_data;
    #1;
    q = rd_data_q;
    a = ack_q;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_boost_ctrl_config_status_regs.sv ***
// Self-checking bench for the configuration and status register bank.
// Assumes the host port model drives the register port; monitors are driven here.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_boost_ctrl_config_status_regs;
  typedef struct packed {logic [7:0] ofs; logic [7:0] wd; logic [7:0] exp;} row_t;
  logic clk, rst, ce, busy, booted, ptr_load, wr_strobe, rd_strobe, ack_q, nack_q, oe, pin;
  logic [7:0] ptr_value, wr_data, rd_data_q, ptr_q, fault_flags_q, q;
  logic a;
  boost_regs_pkg::monitor_in_t mon;
  boost_regs_pkg::power_ctrl_t ctrl_q;
  int failures = 0;
  int n_checks = 0;
  row_t rows[6] = '{'{8'h02, 8'h5A, 8'h5A}, '{8'h03, 8'hC6, 8'hC6}, '{8'h04, 8'hFF, 8'h09},
    '{8'h05, 8'hFF, 8'h00}, '{8'h07, 8'hFF, 8'h00}, '{8'h01, 8'hFF, 8'h00}};
  logic [7:0] dead_ns[8] = '{8'h0E, 8'h1E, 8'h32, 8'h4B, 8'h64, 8'h7D, 8'h96, 8'hC8};
  logic [6:0] warn_c[4] = '{7'h14, 7'h23, 7'h32, 7'h46};
  boost_ctrl_config_status_regs i_boost_ctrl_config_status_regs (.clk(clk), .rst(rst),
    .ce(ce), .booted(booted), .busy(busy), .ptr_load(ptr_load), .ptr_value(ptr_value),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe), .mon(mon),
    .rd_data_q(rd_data_q), .ack_q(ack_q), .nack_q(nack_q), .ptr_q(ptr_q),
    .fault_flags_q(fault_flags_q), .fault_pin_out_q(pin), .fault_pin_oe_q(oe),
    .ctrl_q(ctrl_q));
  host_port_model i_host_port_model (.clk(clk), .rd_data_q(rd_data_q), .ack_q(ack_q),
    .ptr_load(ptr_load), .ptr_value(ptr_value), .wr_strobe(wr_strobe), .wr_data(wr_data),
    .rd_strobe(rd_strobe));
  // ****
  // Clock, helpers and closing.
  // ****
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    i_host_port_model.xfer(0, o, q, a);
    i_host_port_model.xfer(1, d, q, a);
  endtask
  task automatic rd(input logic [7:0] o);
    i_host_port_model.xfer(0, o, q, a);
    i_host_port_model.xfer(2, 8'h00, q, a);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle(1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
  // ****
  // Main sequence.
  // ****
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    busy = 1'b0;
    booted = 1'b1;
    mon = '0;
    mon.run_phase = 4'h9;
    mon.temp_margin_c = 8'hC8;
    do_reset();
    rd(8'h02);
    `CHK(q, 8'h80)
    `CHK(ctrl_q.dead_time_ns, 8'h64)
    `CHK(ctrl_q.warn_margin_c, 7'h32)
    `CHK(ctrl_q.dither_en, 1'b0)
    i_host_port_model.xfer(2, 8'h00, q, a);
    `CHK(q, 8'hA1)
    $display("reset values done");
    foreach (rows[i]) begin
      wr(rows[i].ofs, rows[i].wd);
      rd(rows[i].ofs);
      `CHK(q, rows[i].exp)
      `CHK(a, 1'b1)
    end
    $display("register table done");
    wr(8'h02, 8'h84);
    for (int r = 0; r < 8; r++) begin
      wr(8'h03, {r[1:0], r[2:0], r[2:0]});
      settle(1);
      `CHK(ctrl_q.dead_time_ns, dead_ns[r])
      `CHK(ctrl_q.warn_margin_c, warn_c[r[1:0]])
      `CHK(ctrl_q.dither_en, r == 0 || r == 2 || r == 3)
      `CHK(ctrl_q.sync_input_en, !(r == 0 || r == 2 || r == 3))
      `CHK(ctrl_q.sync_output_en, r >= 2 && r <= 5)
      `CHK(ctrl_q.phase2_deg, (r == 2 || r == 4) ? 9'h0F0 : 9'h0B4)
      `CHK(ctrl_q.sync_shift_deg, (r == 2 || r == 4) ? 7'h78 :
        (r == 3 || r == 5) ? 7'h5A : 7'h00)
    end
    $display("role table done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h02, {1'b1, m[1:0], 3'h0, m[0], m[1]});
      settle(1);
      `CHK(ctrl_q.forced_pulse_width, m[1])
      `CHK(ctrl_q.diode_emulation, !m[1])
      `CHK(ctrl_q.phase2_en, m[0])
      `CHK(ctrl_q.lockout_ok, m[1])
    end
    mon.mode_pin_forced_pulse_width <= 1'b1;
    mon.en2_pin <= 1'b1;
    mon.lockout_pin_ok <= 1'b1;
    wr(8'h02, 8'h80);
    settle(1);
    `CHK(ctrl_q.forced_pulse_width, 1'b1)
    `CHK(ctrl_q.phase2_en, 1'b1)
    `CHK(ctrl_q.lockout_ok, 1'b1)
    `CHK(ctrl_q.ov_hysteresis_en, 1'b0)
    mon.mode_pin_forced_pulse_width <= 1'b0;
    mon.en2_pin <= 1'b0;
    mon.lockout_pin_ok <= 1'b0;
    $display("mode table done");
    wr(8'h02, 8'h80);
    mon.ov_detect <= 1'b1;
    settle(2);
    `CHK(oe, 1'b0)
    `CHK(pin, 1'b0)
    wr(8'h02, 8'h90);
    settle(1);
    `CHK(oe, 1'b1)
    mon.ov_detect <= 1'b0;
    mon.uv_detect <= 1'b1;
    wr(8'h02, 8'h80);
    settle(1);
    `CHK(oe, 1'b1)
    mon.uv_detect <= 1'b0;
    $display("fault pin done");
    i_host_port_model.xfer(0, 8'h06, q, a);
    i_host_port_model.xfer(2, 8'h00, q, a);
    settle(1);
    `CHK(fault_flags_q, 8'h00)
    @(posedge clk);
    mon.avg_input_limit <= 1'b1;
    mon.thermal_shutdown <= 1'b1;
    mon.high_side_supply_uv <= 1'b1;
    mon.comm_logic_memory_error <= 1'b1;
    mon.peak_over20 <= 1'b1;
    mon.temp_margin_c <= 8'h32;
    @(posedge clk);
    mon.avg_input_limit <= 1'b0;
    mon.thermal_shutdown <= 1'b0;
    mon.high_side_supply_uv <= 1'b0;
    mon.comm_logic_memory_error <= 1'b0;
    mon.peak_over20 <= 1'b0;
    mon.temp_margin_c <= 8'hC8;
    settle(3);
    rd(8'h05);
    `CHK(q, 8'hF3)
    i_host_port_model.xfer(2, 8'h00, q, a);
    settle(2);
    `CHK(fault_flags_q, 8'h00)
    `CHK(ptr_q, 8'h07)
    $display("fault latch done");
    i_host_port_model.xfer(0, 8'h02, q, a);
    busy <= 1'b1;
    i_host_port_model.xfer(1, 8'h00, q, a);
    `CHK(a, 1'b0)
    `CHK(nack_q, 1'b1)
    busy <= 1'b0;
    booted <= 1'b0;
    i_host_port_model.xfer(2, 8'h00, q, a);
    `CHK(a, 1'b0)
    `CHK(nack_q, 1'b1)
    booted <= 1'b1;
    rd(8'h02);
    `CHK(q, 8'h80)
    $display("refusal done");
    i_host_port_model.xfer(0, 8'h02, q, a);
    ce <= 1'b0;
    i_host_port_model.xfer(1, 8'h00, q, a);
    `CHK(a, 1'b0)
    `CHK(ptr_q, 8'h02)
    ce <= 1'b1;
    rd(8'h02);
    `CHK(q, 8'h80)
    $display("clock enable done");
    @(posedge clk);
    mon.ovmax_detect <= 1'b1;
    @(posedge clk);
    mon.ovmax_detect <= 1'b0;
    settle(4);
    `CHK(ctrl_q.shutdown, 1'b1)
    `CHK(fault_flags_q[3], 1'b1)
    do_reset();
    `CHK(ctrl_q.shutdown, 1'b0)
    `CHK(fault_flags_q, 8'h00)
    $display("shutdown latch done");
    wr(8'h02, 8'h08);
    @(posedge clk);
    mon.ovmax_detect <= 1'b1;
    @(posedge clk);
    mon.ovmax_detect <= 1'b0;
    settle(2);
    `CHK(ctrl_q.shutdown, 1'b0)
    `CHK(ctrl_q.ov_hysteresis_en, 1'b1)
    @(posedge clk);
    mon.peak_over20 <= 1'b1;
    @(posedge clk);
    mon.peak_over20 <= 1'b0;
    settle(2);
    `CHK(ctrl_q.shutdown, 1'b1)
    $display("protection options done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
